// >>> rtl/emb_memory_array.sv
/*
 * column of embedded memory blocks with one shape shared by all blocks, side-by-side wide mode and
 * page-decoded deep mode onto a shared column line.
 * assumes user logic drives request and data synchronous to clk_sys from neighbouring
 * logic elements, and that configuration inputs are static while requests flow.
 */
`timescale 1ns/1ps
`include "emb_regs.svh"

module emb_memory_array
	import emb_pkg::*;
#(
	parameter int NUM_BLOCKS = `EMB_NUM_BLOCKS,
	parameter int BLOCK_BITS = `EMB_BLOCK_BITS
)(
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	// configuration
	input wire emb_shape_t cfgShape,
	input wire logic cfgDeep,
	input wire logic [NUM_BLOCKS*`EMB_PAGE_BITS-1:0] cfgPageId,
	// request from local routing
	input wire emb_req_t req,
	input wire logic [NUM_BLOCKS*`EMB_MAX_W-1:0] wrData,
	// read results
	output logic [NUM_BLOCKS*`EMB_MAX_W-1:0] rdWide_ff,
	output logic [`EMB_MAX_W-1:0] colLine_ff,
	output logic [NUM_BLOCKS-1:0] driveEn_ff,
	output logic parkEn_ff,
	output logic rdValid_ff,
	output logic [`EMB_LOCAL_OUTS-1:0] localOut_ff
);

	localparam int MW = `EMB_MAX_W;
	localparam int AW = `EMB_WORD_AW;
	localparam int PB = `EMB_PAGE_BITS;

	// refused at elaboration: the address split only serves 2048-bit blocks and four pages
	if (BLOCK_BITS != `EMB_BLOCK_BITS)
	begin : gBadBits
		$error("block size must match the 11-bit word address");
	end
	if (NUM_BLOCKS < 1 || NUM_BLOCKS > (1 << PB))
	begin : gBadCount
		$error("column holds one to four blocks");
	end

	// bit offset of a word: address masked to the shape depth, scaled by width
	function automatic logic [AW-1:0] bitBase(input logic [AW-1:0] a, input emb_shape_t s);
		logic [AW-1:0] m;
		m = {AW{1'b1}} >> s;
		return (a & m) << s;
	endfunction

	logic [BLOCK_BITS-1:0] memBits_ff [NUM_BLOCKS];
	logic [MW-1:0] blkRead [NUM_BLOCKS];
	logic [NUM_BLOCKS-1:0] rdHit;
	logic [NUM_BLOCKS-1:0] wrHit;
	logic [NUM_BLOCKS-1:0] nxt_driveEn;
	logic [MW-1:0] nxt_colLine;
	logic [AW-1:0] rdBase;
	logic [AW-1:0] wrBase;
	logic [PB-1:0] rdPage;
	logic [PB-1:0] wrPage;
	logic [AW-1:0] wrAddr_ff;
	logic [PB-1:0] wrPage_ff;
	logic [NUM_BLOCKS*MW-1:0] wrData_ff;
	logic wrStrobe_ff;

	// low bits address every block, upper bits go to the page decoders
	assign rdBase = bitBase(req.addr[AW-1:0], cfgShape);
	assign rdPage = req.addr[`EMB_ADDR_W-1:AW];
	assign wrBase = bitBase(wrAddr_ff, cfgShape);
	assign wrPage = wrPage_ff;

	// capture the write, commit it on the next edge with an internal strobe;
	// a read of that word in the strobe cycle still returns the old contents
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			wrStrobe_ff <= 1'b0;
			wrAddr_ff <= '0;
			wrPage_ff <= '0;
			wrData_ff <= '0;
		end
		else if (ce)
		begin
			wrStrobe_ff <= req.wrEn;
			if (req.wrEn)
			begin
				wrAddr_ff <= req.addr[AW-1:0];
				wrPage_ff <= rdPage;
				wrData_ff <= wrData;
			end
		end
	end

	genvar b;
	generate
		for (b = 0; b < NUM_BLOCKS; b++)
		begin : gBlk
			// programmable page decoder per block
			assign rdHit[b] = cfgDeep && (rdPage == cfgPageId[b*PB +: PB]);
			assign wrHit[b] = !cfgDeep || (wrPage == cfgPageId[b*PB +: PB]);

			always_ff @(posedge clk_sys)
			begin
				if (ce && wrStrobe_ff && wrHit[b])
				begin
					for (int i = 0; i < MW; i++)
					begin
						if (i < (1 << cfgShape))
						begin
							if (cfgDeep)
								memBits_ff[b][wrBase + AW'(i)] <= wrData_ff[i];
							else
								memBits_ff[b][wrBase + AW'(i)] <= wrData_ff[b*MW + i];
						end
					end
				end
			end

			always_comb
			begin
				blkRead[b] = '0;
				for (int i = 0; i < MW; i++)
				begin
					if (i < (1 << cfgShape))
						blkRead[b][i] = memBits_ff[b][rdBase + AW'(i)];
				end
			end

			// wide mode: each block owns its slice; deep mode: slices stay quiet
			always_ff @(posedge clk_sys)
			begin
				if (sys_rst)
					rdWide_ff[b*MW +: MW] <= '0;
				else if (ce && req.rdEn)
					rdWide_ff[b*MW +: MW] <= cfgDeep ? '0 : blkRead[b];
			end
		end
	endgenerate

	// first matching block wins, so a misprogrammed decoder cannot cause contention
	always_comb
	begin
		logic taken;
		taken = 1'b0;
		nxt_driveEn = '0;
		nxt_colLine = '0;
		for (int k = 0; k < NUM_BLOCKS; k++)
		begin
			if (rdHit[k] && !taken)
			begin
				nxt_driveEn[k] = 1'b1;
				nxt_colLine = blkRead[k];
				taken = 1'b1;
			end
		end
	end

	// column line with its keeper: parked at zero when no page matches
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			colLine_ff <= '0;
			driveEn_ff <= '0;
			parkEn_ff <= 1'b1;
		end
		else if (ce && req.rdEn)
		begin
			colLine_ff <= nxt_colLine;
			driveEn_ff <= nxt_driveEn;
			parkEn_ff <= ~|nxt_driveEn;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			rdValid_ff <= 1'b0;
		else if (ce)
			rdValid_ff <= req.rdEn;
	end

	// ten local lines, the top one repeats bit eight
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			localOut_ff <= '0;
		else if (ce && req.rdEn)
		begin
			if (cfgDeep)
				localOut_ff <= {nxt_colLine[8], nxt_colLine[8:0]};
			else
				localOut_ff <= {blkRead[0][8], blkRead[0][8:0]};
		end
	end

	default clocking cbSys @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence seqWrite;
		ce && req.wrEn;
	endsequence

	sequence seqRead;
		ce && req.rdEn;
	endsequence

	write_strobe_a: assert property (seqWrite |=> wrStrobe_ff)
		else $error("write strobe missing after write request");
	read_latency_a: assert property (seqRead |=> rdValid_ff)
		else $error("read data not marked one cycle after address");
	shape_width_a: assert property ((seqRead and (!cfgDeep && cfgShape == SHAPE_X1))
		|=> rdWide_ff[MW-1:1] == '0)
		else $error("bits above word width not zero");
	line_owner_a: assert property ((seqRead and (cfgDeep))
		|=> $onehot({parkEn_ff, driveEn_ff}))
		else $error("column line has none or several drivers");
	driver_off_a: assert property ((seqRead and (!cfgDeep))
		|=> driveEn_ff == '0 && parkEn_ff)
		else $error("line driver on outside deep mode");
	deep_slices_a: assert property ((seqRead and (cfgDeep)) |=> rdWide_ff == '0)
		else $error("block output used in deep mode");
	local_dup_a: assert property (rdValid_ff |-> localOut_ff[9] == localOut_ff[8])
		else $error("duplicate local output differs");
	page_decode_a: assert property ((seqRead and (cfgDeep && rdPage == cfgPageId[PB-1:0]))
		|=> driveEn_ff[0])
		else $error("block zero not driving its own page");
	wide_read_a: assert property ((seqRead and (!cfgDeep))
		|=> rdWide_ff[MW-1:0] == $past(blkRead[0]))
		else $error("wide slice mismatch");

endmodule

// >>> rtl/emb_pkg.sv
/*
 * types shared by the embedded memory block column.
 * assumes emb_regs.svh is on the include path.
 */
`include "emb_regs.svh"

package emb_pkg;

	// shape code is log2 of the word width
	typedef enum logic [`EMB_SHAPE_W-1:0] {
		SHAPE_X1 = 3'h0,
		SHAPE_X2 = 3'h1,
		SHAPE_X4 = 3'h2,
		SHAPE_X8 = 3'h3,
		SHAPE_X16 = 3'h4
	} emb_shape_t;

	typedef struct packed {
		logic [`EMB_ADDR_W-1:0] addr;
		logic wrEn;
		logic rdEn;
	} emb_req_t;

endpackage

// >>> rtl/emb_regs.svh
/*
 * constants for the embedded memory block column: storage size, address split,
 * widest word and the local routing fan-out.
 * assumes it is included by bare name from the package and the design file.
 */
`ifndef EMB_REGS_SVH
`define EMB_REGS_SVH

`define EMB_BLOCK_BITS 2048
`define EMB_WORD_AW 11
`define EMB_PAGE_BITS 2
`define EMB_ADDR_W 13
`define EMB_MAX_W 16
`define EMB_LOCAL_OUTS 10
`define EMB_NUM_BLOCKS 4
`define EMB_SHAPE_W 3

`endif

// >>> test/emb_memory_array_tb.sv
/*
 * random write then read-back over every shape, wide and deep, plus a deep pass
 * with a shared page and an unowned page; expectations from a bench copy of memory.
 * assumes the design's default four blocks and the one-cycle read latency.
 */
`timescale 1ns/1ps
module emb_memory_array_tb;
	import emb_pkg::*;
	logic clk_sys = 0;
	logic sys_rst = 1;
	logic ce = 1'b1;
	emb_shape_t cfgShape = SHAPE_X1;
	logic cfgDeep = 0;
	logic [7:0] cfgPageId = 8'he4;
	emb_req_t nReq = '0;
	emb_req_t req;
	logic [63:0] nData = '0;
	logic [63:0] wrData;
	logic [63:0] rdWide_ff;
	logic [15:0] colLine_ff;
	logic [3:0] driveEn_ff;
	logic parkEn_ff;
	logic rdValid_ff;
	logic [9:0] localOut_ff;
	int err_count = 0;
	int cmp_count = 0;
	logic [31:0] seed = 32'h0000_14cf;
	logic [63:0] refm [8192];
	logic [12:0] addrs [$];

	emb_memory_array u_emb_memory_array (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
		.cfgShape(cfgShape), .cfgDeep(cfgDeep), .cfgPageId(cfgPageId), .req(req),
		.wrData(wrData), .rdWide_ff(rdWide_ff), .colLine_ff(colLine_ff),
		.driveEn_ff(driveEn_ff), .parkEn_ff(parkEn_ff), .rdValid_ff(rdValid_ff),
		.localOut_ff(localOut_ff));
	emb_user_logic u_emb_user_logic (.clk_sys(clk_sys), .nReq(nReq), .nData(nData),
		.req(req), .wrData(wrData));

	initial
	begin
		forever #20 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// lowest block owning the page drives; -1 when nobody owns it
	function automatic int owner(logic [1:0] pg);
		for (int b = 0; b < 4; b++)
			if (cfgPageId[2*b+:2] == pg)
				return b;
		return -1;
	endfunction

	task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic run_pass(logic d, int s);
		logic [63:0] m;
		logic [63:0] x;
		logic [63:0] rw;
		logic [12:0] a;
		logic [15:0] col;
		int key;
		int o;
		m = (64'h1 << (1 << s)) - 64'h1;
		cfgDeep = d;
		cfgShape = emb_shape_t'(s);
		addrs.delete();
		for (int i = 0; i < 6; i++)
		begin
			a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1fff : 13'(rnd());
			x = {rnd(), rnd()};
			key = (d ? a[12:11] * 2048 : 0) + (a[10:0] & (2047 >> s));
			refm[key] = x;
			addrs.push_back(a);
			nReq = '{addr: a, wrEn: 1'b1, rdEn: 1'b0};
			nData = x;
			@(negedge clk_sys);
		end
		nReq = '0;
		@(negedge clk_sys);
		foreach (addrs[i])
		begin
			a = addrs[i];
			key = (d ? a[12:11] * 2048 : 0) + (a[10:0] & (2047 >> s));
			x = refm[key] & (d ? m : {4{m[15:0]}});
			o = d ? owner(a[12:11]) : -1;
			col = (o < 0) ? 16'h0000 : x[15:0];
			rw = d ? 64'h0 : x;
			if (i == 0)
			begin
				// enable low: this write must never land, so the read below still sees x
				ce = 1'b0;
				nReq = '{addr: a, wrEn: 1'b1, rdEn: 1'b1};
				nData = ~x;
				@(negedge clk_sys);
				chk("rdValid frozen", 0, rdValid_ff);
				ce = 1'b1;
				nReq = '0;
				@(negedge clk_sys);
				chk("rdValid after freeze", 0, rdValid_ff);
			end
			nReq = '{addr: a, wrEn: 1'b0, rdEn: 1'b1};
			@(negedge clk_sys);
			chk("rdValid", 1, rdValid_ff);
			chk("rdWide", rw, rdWide_ff);
			chk("colLine", col, colLine_ff);
			chk("driveEn", (o < 0) ? 0 : 1 << o, driveEn_ff);
			chk("parkEn", o < 0, parkEn_ff);
			col = d ? col : rw[15:0];
			chk("localOut", {col[8], col[8:0]}, localOut_ff);
			nReq = '0;
			@(negedge clk_sys);
			chk("rdValid idle", 0, rdValid_ff);
		end
		$display("pass deep %0d shape %0d done", d, s);
	endtask

	initial
	begin
		repeat (20) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 0;
		chk("parkEn reset", 1, parkEn_ff);
		for (int d = 0; d < 2; d++)
			for (int s = 0; s < 5; s++)
				run_pass(d[0], s);
		// two blocks share page 2 and page 3 has no owner
		cfgPageId = 8'ha4;
		run_pass(1'b1, 2);
		print_verdict();
	end

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		print_verdict();
	end
endmodule

// >>> test/emb_user_logic.sv
/*
 * model of the neighbouring logic element that feeds the memory column.
 * assumes the bench hands it one request and one data word per clock.
 */
`timescale 1ns/1ps
module emb_user_logic
	import emb_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// bench side
	input wire emb_req_t nReq,
	input wire logic [63:0] nData,
	// toward the memory column
	output emb_req_t req,
	output logic [63:0] wrData
);
	logic [63:0] lastData_ff = '0;
	// the element drives the column inputs straight, no extra stage
	assign req = nReq;
	// outside writes the data lines flip, so stale data is never taken
	assign wrData = nReq.wrEn ? nData : ~lastData_ff;
	always_ff @(posedge clk_sys)
	begin
		if (nReq.wrEn)
			lastData_ff <= nData;
	end
endmodule
